// file: verilog/pmh_params.svh
// Constants for the positioner move handshake block
`ifndef PMH_PARAMS_SVH
`define PMH_PARAMS_SVH

`define PMH_CLK_HZ          100000000
`define PMH_TICK_MS         1
`define PMH_TICK_CYC        ((`PMH_CLK_HZ / 1000) * `PMH_TICK_MS)
`define PMH_PUSH_TIME_MAX   16'h270F
`define PMH_PUSH_TIME_RST   16'h00FF
`define PMH_PAUSE_PAT_MAX   3'h4

`define PMH_REG_CTRL        4'h0
`define PMH_REG_PUSH_TIME   4'h1
`define PMH_REG_IO_PAT      4'h2
`define PMH_REG_STATUS      4'h3
`define PMH_REG_TARGET      4'h4
`define PMH_REG_DONE_POS    4'h5
`define PMH_REG_ACCEL       4'h6
`define PMH_REG_DECEL       4'h7

`define PMH_CTRL_STATUS_RO  1'b1

`endif

// file: verilog/pmh_pkg.sv
// Types for the positioner move handshake block
package pmh_pkg;
    typedef enum logic [4:0] {
        PMH_IDLE    = 5'b00001,
        PMH_MOVE    = 5'b00010,
        PMH_PUSH    = 5'b00100,
        PMH_PAUSED  = 5'b01000,
        PMH_DONE    = 5'b10000
    } pmh_state_e;
    typedef logic [31:0] pmh_pos_t;
endpackage : pmh_pkg

// file: verilog/pmh_push_judge.sv
// Push-and-hold judgment up/down millisecond counter
`timescale 1ns/1ps
`include "pmh_params.svh"
module pmh_push_judge
    import pmh_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        ms_tick,
    input  wire logic        at_limit,
    input  wire logic [15:0] judge_time,
    output logic             judged,
    output logic      [15:0] count
);
    logic [15:0] count_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
        end else if (clear) begin
            count_reg <= 16'h0000;
        end else if (ms_tick) begin
            if (at_limit && count_reg < judge_time) begin
                count_reg <= count_reg + 16'h0001;
            end else if (!at_limit && count_reg != 16'h0000) begin
                count_reg <= count_reg - 16'h0001;
            end
        end
    end

    assign count  = count_reg;
    assign judged = (judge_time != 16'h0000) && (count_reg >= judge_time);

    count_up_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clear && ms_tick && at_limit && count_reg < judge_time
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("judge counter did not count up");
    count_down_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clear && ms_tick && !at_limit && count_reg != 16'h0000
        |=> count_reg == $past(count_reg) - 16'h0001)
        else $error("judge counter did not count down");
endmodule : pmh_push_judge

// file: verilog/pmh_move_handshake.sv
// Positioner move handshake and sequencing with Avalon-MM registers
// Contract
// - Push completes after current held at limit for judgment time.
// - Judgment time programmable in 1 ms steps, max 9999, default 255.
// - Judgment counter counts up at limit, down below, keeps value.
// - Relative positioning after push uses push entry target as base.
// - Relative push after push uses push finish position as base.
// - Push reaching travel end unjudged is a miss, no complete.
// - On miss, report reached position and drop moving.
// - Start rising clears position-complete and sets moving.
// - Position-complete held off while start stays asserted.
// - Start to current position clears complete, moving stays off.
// - Moving clears in the same cycle position-complete turns on; if start is still high, complete follows when start falls.
// - Reaching soft stroke limit stops a non-push move immediately with complete.
// - New start during wide-band motion retargets with new speed.
// - Pause halts motion, only in io patterns 0 to 4.
// - Reset rising edge while paused cancels remaining movement.
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pmh_params.svh"
module pmh_move_handshake
    import pmh_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        start,
    input  wire logic        pause,
    input  wire logic        reset_in,
    input  wire logic [31:0] entry_position,
    input  wire logic        entry_incremental,
    input  wire logic        entry_push,
    input  wire logic [31:0] entry_band,
    input  wire logic [15:0] entry_speed,
    input  wire logic [15:0] entry_accel,
    input  wire logic [15:0] entry_decel,
    input  wire logic [31:0] actual_position,
    input  wire logic        current_at_limit,
    input  wire logic        travel_end,
    input  wire logic [31:0] soft_limit_lo,
    input  wire logic [31:0] soft_limit_hi,
    output logic             position_complete,
    output logic             moving,
    output logic             motion_enable,
    output logic      [31:0] motion_target,
    output logic      [15:0] motion_speed,
    output logic      [15:0] motion_accel,
    output logic      [15:0] motion_decel,
    output logic             push_active
);
    localparam int TICK_CYC = `PMH_TICK_CYC;

    pmh_state_e  state_reg;
    logic [31:0] tick_cnt_reg;
    logic        ms_tick;
    logic        start_d_reg;
    logic        reset_d_reg;
    logic        start_rise;
    logic        reset_rise;
    logic [15:0] push_time_reg;
    logic [2:0]  io_pat_reg;
    logic        last_push_reg;
    logic        last_missed_reg;
    logic [31:0] push_target_reg;
    logic [31:0] push_done_pos_reg;
    logic [31:0] base_pos;
    logic [31:0] new_target;
    logic [31:0] clip_target;
    logic [31:0] pos_diff;
    logic        in_band;
    logic        at_soft_limit;
    logic        judged;
    logic        judge_clear;
    logic        pause_ok;
    logic [15:0] judge_count;
    logic        ack_reg;
    logic [31:0] band_reg;

    // Millisecond tick
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else if (tick_cnt_reg == 32'(TICK_CYC - 1)) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        end
    end
    assign ms_tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_d_reg <= 1'b0;
            reset_d_reg <= 1'b0;
        end else begin
            start_d_reg <= start;
            reset_d_reg <= reset_in;
        end
    end
    assign start_rise = start && !start_d_reg;
    assign reset_rise = reset_in && !reset_d_reg;

    // Target computation for new moves: relative base, push bases and soft-limit clip
    always_comb begin
        base_pos = actual_position;
        if (state_reg == PMH_MOVE || state_reg == PMH_PUSH) begin
            base_pos = motion_target;
        end
        if (last_push_reg && state_reg == PMH_DONE) begin
            base_pos = entry_push ? push_done_pos_reg
                                  : push_target_reg;
        end
        new_target = entry_incremental ? base_pos + entry_position
                                       : entry_position;
        clip_target = new_target;
        if ($signed(new_target) > $signed(soft_limit_hi)) begin
            clip_target = soft_limit_hi;
        end else if ($signed(new_target) < $signed(soft_limit_lo)) begin
            clip_target = soft_limit_lo;
        end
    end

    assign pos_diff = ($signed(actual_position) >= $signed(motion_target))
                    ? actual_position - motion_target
                    : motion_target - actual_position;
    assign in_band = (pos_diff <= band_reg);
    assign at_soft_limit = (actual_position == soft_limit_hi)
                        || (actual_position == soft_limit_lo);
    assign pause_ok = (io_pat_reg <= `PMH_PAUSE_PAT_MAX);
    assign judge_clear = (state_reg != PMH_PUSH);

    pmh_push_judge u_judge (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clear      (judge_clear),
        .ms_tick    (ms_tick),
        .at_limit   (current_at_limit),
        .judge_time (push_time_reg),
        .judged     (judged),
        .count      (judge_count)
    );

    // Move sequencing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= PMH_IDLE;
            motion_target   <= 32'h0000_0000;
            motion_speed    <= 16'h0000;
            motion_accel    <= 16'h0000;
            motion_decel    <= 16'h0000;
            band_reg        <= 32'h0000_0000;
            push_active     <= 1'b0;
            last_push_reg   <= 1'b0;
            last_missed_reg <= 1'b0;
            push_target_reg <= 32'h0000_0000;
            push_done_pos_reg <= 32'h0000_0000;
        end else if (start_rise && state_reg != PMH_PAUSED) begin
            motion_target <= clip_target;
            motion_speed  <= entry_speed;
            motion_accel  <= entry_accel;
            motion_decel  <= entry_decel;
            band_reg      <= entry_band;
            push_active   <= entry_push;
            last_missed_reg <= 1'b0;
            if (entry_push) begin
                push_target_reg <= clip_target;
                state_reg       <= PMH_PUSH;
            end else if (clip_target == actual_position) begin
                state_reg <= PMH_DONE;
            end else begin
                state_reg <= PMH_MOVE;
            end
        end else begin
            unique case (state_reg)
                PMH_IDLE: begin
                end
                PMH_MOVE: begin
                    if (pause && pause_ok) begin
                        state_reg <= PMH_PAUSED;
                    end else if (in_band || at_soft_limit) begin
                        state_reg     <= PMH_DONE;
                        last_push_reg <= 1'b0;
                    end
                end
                PMH_PUSH: begin
                    if (pause && pause_ok) begin
                        state_reg <= PMH_PAUSED;
                    end else if (judged) begin
                        state_reg         <= PMH_DONE;
                        push_done_pos_reg <= actual_position;
                        last_push_reg     <= 1'b1;
                        push_active       <= 1'b0;
                    end else if (travel_end) begin
                        state_reg         <= PMH_DONE;
                        last_missed_reg   <= 1'b1;
                        push_done_pos_reg <= actual_position;
                        last_push_reg     <= 1'b1;
                        push_active       <= 1'b0;
                    end
                end
                PMH_PAUSED: begin
                    if (reset_rise) begin
                        state_reg   <= PMH_IDLE;
                        push_active <= 1'b0;
                    end else if (!pause) begin
                        state_reg <= push_active ? PMH_PUSH : PMH_MOVE;
                    end
                end
                PMH_DONE: begin
                end
            endcase
        end
    end

    // Handshake outputs
    assign moving = (state_reg == PMH_MOVE) || (state_reg == PMH_PUSH)
                 || (state_reg == PMH_PAUSED);
    assign position_complete = (state_reg == PMH_DONE) && !start
                            && !last_missed_reg;
    assign motion_enable = (state_reg == PMH_MOVE) || (state_reg == PMH_PUSH);

    // Avalon-MM slave: one wait cycle per access
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            push_time_reg <= `PMH_PUSH_TIME_RST;
            io_pat_reg    <= 3'h0;
        end else if (avs_write && ack_reg) begin
            if (avs_address == `PMH_REG_PUSH_TIME
                && avs_writedata[31:16] == 16'h0000
                && avs_writedata[15:0] != 16'h0000
                && avs_writedata[15:0] <= `PMH_PUSH_TIME_MAX) begin
                push_time_reg <= avs_writedata[15:0];
            end
            if (avs_address == `PMH_REG_IO_PAT) begin
                io_pat_reg <= avs_writedata[2:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            unique case (avs_address)
                `PMH_REG_PUSH_TIME: avs_readdata <= {16'h0000, push_time_reg};
                `PMH_REG_IO_PAT:    avs_readdata <= {29'h0, io_pat_reg};
                `PMH_REG_STATUS:    avs_readdata <= {8'h00, judge_count,
                    last_missed_reg, position_complete, moving, state_reg};
                `PMH_REG_TARGET:    avs_readdata <= motion_target;
                `PMH_REG_DONE_POS:  avs_readdata <= push_done_pos_reg;
                `PMH_REG_ACCEL:     avs_readdata <= {16'h0000, motion_accel};
                `PMH_REG_DECEL:     avs_readdata <= {16'h0000, motion_decel};
                default:            avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    start_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        start |-> !position_complete)
        else $error("complete on while start high");
    exclusive_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(moving && position_complete))
        else $error("moving and complete together");
    start_moves_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        start_rise && state_reg == PMH_IDLE && !entry_push
        && clip_target != actual_position |=> moving)
        else $error("start did not set moving");
    same_pos_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        start_rise && state_reg != PMH_PAUSED && !entry_push
        && clip_target == actual_position |=> !moving)
        else $error("moving set for same position");
    miss_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == PMH_PUSH && !start_rise && !pause && !judged
        && travel_end |=> !moving && !position_complete)
        else $error("missed load handled wrongly");
    band_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == PMH_MOVE && !start_rise && !pause && in_band
        ##1 !start |-> position_complete)
        else $error("no complete inside band");
    pause_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == PMH_MOVE && !start_rise && pause && pause_ok
        |=> !motion_enable)
        else $error("pause did not halt");
    cancel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == PMH_PAUSED && reset_rise |=> state_reg == PMH_IDLE)
        else $error("reset edge did not cancel");
    push_default_a: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> push_time_reg == 16'h00FF)
        else $error("push time default wrong");
    soft_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == PMH_MOVE && !start_rise && !pause && at_soft_limit
        |=> state_reg == PMH_DONE)
        else $error("no stop at soft limit");
endmodule : pmh_move_handshake

// file: verif/pmh_host_model.sv
// Host controller model driving the discrete command inputs
`timescale 1ns/1ps
module pmh_host_model #(
    parameter int SETUP_CYC = 600000
) (
    input  wire logic        sys_clk,
    input  wire logic        position_complete,
    output logic             start,
    output logic             pause,
    output logic             reset_in,
    output logic      [31:0] entry_position,
    output logic             entry_incremental,
    output logic             entry_push,
    output logic      [31:0] entry_band,
    output logic      [15:0] entry_speed,
    output logic      [15:0] entry_accel,
    output logic      [15:0] entry_decel
);
    initial begin
        {start, pause, reset_in, entry_incremental, entry_push} = 5'h0;
        {entry_position, entry_band} = 64'h0;
        {entry_speed, entry_accel, entry_decel} = 48'h0;
    end

    // Entry is held steady for the setup span before any start
    task automatic select(input logic [31:0] pos, input logic inc, psh,
                          input logic [31:0] band, input logic [15:0] spd,
                          input logic [15:0] acc, dec);
        @(posedge sys_clk);
        entry_position    <= pos;
        entry_incremental <= inc;
        entry_push        <= psh;
        entry_band        <= band;
        entry_speed       <= spd;
        entry_accel       <= acc;
        entry_decel       <= dec;
        repeat (SETUP_CYC) @(posedge sys_clk);
    endtask : select

    task automatic raise_start;
        @(posedge sys_clk);
        start <= 1'b1;
    endtask : raise_start

    // Drop start once complete has been seen low, or after 100 cycles at most
    task automatic release_start;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (position_complete !== 1'b0 && n < 100);
        start <= 1'b0;
    endtask : release_start

    task automatic hold(input logic p, r);
        @(posedge sys_clk);
        pause    <= p;
        reset_in <= r;
    endtask : hold
endmodule : pmh_host_model

// file: verif/pmh_move_handshake_test.sv
// Self-checking bench for the move handshake block
`timescale 1ns/1ps
`include "pmh_params.svh"
module pmh_move_handshake_test;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, entry_position, entry_band, motion_target;
    logic        avs_waitrequest, start, pause, reset_in;
    logic        entry_incremental, entry_push;
    logic [15:0] entry_speed, entry_accel, entry_decel;
    logic [31:0] actual_position = 32'h0;
    logic        current_at_limit = 1'b0;
    logic        travel_end = 1'b0;
    logic [31:0] soft_limit_lo = 32'h8000_0000;
    logic [31:0] soft_limit_hi = 32'h7FFF_FFFF;
    logic        position_complete, moving, motion_enable, push_active;
    logic [15:0] motion_speed, motion_accel, motion_decel;
    logic [31:0] q;
    int          mismatches = 0;
    int          checked = 0;

    always #5 sys_clk = ~sys_clk;

    pmh_move_handshake i_dut (.sys_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .start,
        .pause, .reset_in, .entry_position, .entry_incremental, .entry_push,
        .entry_band, .entry_speed, .entry_accel, .entry_decel,
        .actual_position, .current_at_limit, .travel_end, .soft_limit_lo,
        .soft_limit_hi, .position_complete, .moving, .motion_enable,
        .motion_target, .motion_speed, .motion_accel, .motion_decel,
        .push_active);

    pmh_host_model #(.SETUP_CYC(20)) i_host (.sys_clk, .position_complete,
        .start, .pause, .reset_in, .entry_position, .entry_incremental,
        .entry_push, .entry_band, .entry_speed, .entry_accel, .entry_decel);

    task automatic chk(input string w, input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t %s: got %h expected %h", $time, w, g, e);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50) chk("bus wait", 32'h1, 32'h0);
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input string w);
        bus(1'b0, a, 32'h0);
        chk(w, q, e);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic go;
        i_host.raise_start();
        i_host.release_start();
        cyc(2);
    endtask : go

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (position_complete !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        chk("complete on", position_complete, 32'h1);
        chk("moving with complete", moving, 32'h0);
    endtask : wait_done

    task automatic results;
        if (mismatches == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    initial begin
        repeat (150000) @(posedge sys_clk);
        mismatches++;
        results();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(1);
        chk("idle complete", position_complete, 32'h0);
        chk("idle moving", moving, 32'h0);
        rd(`PMH_REG_PUSH_TIME, 32'h0000_00FF, "push rst");
        bus(1'b1, `PMH_REG_PUSH_TIME, 32'h0000_0000);
        bus(1'b1, `PMH_REG_PUSH_TIME, 32'h0000_2710);
        rd(`PMH_REG_PUSH_TIME, 32'h0000_00FF, "push range");
        bus(1'b1, `PMH_REG_PUSH_TIME, 32'h0000_270F);
        rd(`PMH_REG_PUSH_TIME, 32'h0000_270F, "push max");
        rd(4'h0, 32'h0, "unused reg");
        rd(4'hF, 32'h0, "unmapped reg");
        // Start held high through the whole move
        i_host.select(32'h3E8, 1'b0, 1'b0, 32'h5, 16'h0100, 16'h0030,
                      16'h0010);
        i_host.raise_start();
        cyc(2);
        chk("moving on", moving, 32'h1);
        chk("complete off", position_complete, 32'h0);
        chk("target", motion_target, 32'h3E8);
        chk("accel", motion_accel, 32'h30);
        chk("decel", motion_decel, 32'h10);
        actual_position <= 32'h3E6;
        cyc(3);
        chk("in band", moving, 32'h0);
        chk("held off", position_complete, 32'h0);
        i_host.release_start();
        cyc(1);
        chk("released", position_complete, 32'h1);
        actual_position <= 32'h3E8;
        i_host.raise_start();
        cyc(2);
        chk("same pos moving", moving, 32'h0);
        chk("same pos complete", position_complete, 32'h0);
        i_host.release_start();
        wait_done(10);
        i_host.select(32'h7D0, 1'b0, 1'b0, 32'h1F4, 16'h0200, 16'h0030,
                      16'h0030);
        go;
        chk("wide moving", moving, 32'h1);
        actual_position <= 32'h640;
        wait_done(10);
        i_host.select(32'hBB8, 1'b0, 1'b0, 32'h5, 16'h0040, 16'h0030,
                      16'h0030);
        go;
        chk("retarget", motion_target, 32'hBB8);
        chk("new speed", motion_speed, 32'h40);
        actual_position <= 32'hBB7;
        wait_done(10);
        soft_limit_hi <= 32'hC80;
        i_host.select(32'h1F4, 1'b1, 1'b0, 32'h5, 16'h0100, 16'h0030,
                      16'h0030);
        go;
        chk("clip", motion_target, 32'hC80);
        actual_position <= 32'hC80;
        wait_done(10);
        // Push with one millisecond of judgment
        soft_limit_hi <= 32'h7FFF_FFFF;
        bus(1'b1, `PMH_REG_PUSH_TIME, 32'h0000_0001);
        actual_position  <= 32'h1356;
        current_at_limit <= 1'b1;
        i_host.select(32'h1388, 1'b0, 1'b1, 32'h64, 16'h0100, 16'h0030,
                      16'h0030);
        go;
        chk("push active", push_active, 32'h1);
        wait_done(110000);
        chk("push released", push_active, 32'h0);
        current_at_limit <= 1'b0;
        i_host.select(32'hFFFF_FFD8, 1'b1, 1'b0, 32'h5, 16'h0100,
                      16'h0030, 16'h0030);
        go;
        chk("push base", motion_target, 32'h1360);
        actual_position <= 32'h1360;
        wait_done(10);
        // Push that never meets the load
        i_host.select(32'h1770, 1'b0, 1'b1, 32'h64, 16'h0100, 16'h0030,
                      16'h0030);
        go;
        actual_position <= 32'h17D4;
        travel_end      <= 1'b1;
        cyc(3);
        chk("miss moving", moving, 32'h0);
        chk("miss complete", position_complete, 32'h0);
        bus(1'b0, `PMH_REG_STATUS, 32'h0);
        chk("miss flag", {31'h0, q[7]}, 32'h1);
        rd(`PMH_REG_DONE_POS, 32'h17D4, "reached pos");
        i_host.select(32'hFFFF_FFD8, 1'b1, 1'b1, 32'h64, 16'h0100,
                      16'h0030, 16'h0030);
        go;
        chk("push rel base", motion_target, 32'h17AC);
        travel_end <= 1'b0;
        bus(1'b1, `PMH_REG_IO_PAT, 32'h4);
        i_host.select(32'h1B58, 1'b0, 1'b0, 32'h5, 16'h0100, 16'h0030,
                      16'h0030);
        go;
        i_host.hold(1'b1, 1'b0);
        cyc(2);
        chk("paused", motion_enable, 32'h0);
        i_host.hold(1'b1, 1'b1);
        cyc(2);
        chk("cancel moving", moving, 32'h0);
        chk("cancel complete", position_complete, 32'h0);
        i_host.hold(1'b0, 1'b0);
        bus(1'b1, `PMH_REG_IO_PAT, 32'h5);
        go;
        i_host.hold(1'b1, 1'b0);
        cyc(2);
        chk("no pause", motion_enable, 32'h1);
        i_host.hold(1'b0, 1'b0);
        results();
    end
endmodule : pmh_move_handshake_test
